// ### hdl/ftc_consts.vh
`ifndef FTC_CONSTS_VH
`define FTC_CONSTS_VH

// Word offsets within the system control space
`define FTC_OFS_CFG        12'hD14
`define FTC_OFS_PRI        12'hD18
`define FTC_OFS_STAT       12'hD30
`define FTC_OFS_MASK       12'hD34

// Configuration and control fields
`define FTC_CFG_THREAD     0
`define FTC_CFG_TRIG       1
`define FTC_CFG_UNALIGN    3
`define FTC_CFG_ZERO_DIVISOR_TRAP_EN       4

// Handler priority field low bits
`define FTC_PRI_MEM_LO     5
`define FTC_PRI_BUS_LO     13
`define FTC_PRI_USE_LO     21
`define FTC_PRI_W          3

// Event status bits
`define FTC_EV_ZERO_DIVISOR_TRAP_EN        0
`define FTC_EV_UNALIGN     1
`define FTC_EV_TRIG        2
`define FTC_EV_THREAD      3
`define FTC_EV_PRIV        4
`define FTC_EV_W           5

// Reset values
`define FTC_RST_CFG        5'h00
`define FTC_RST_PRI        3'h0
`define FTC_RST_STAT       5'h00
`define FTC_RST_MASK       5'h00

`endif

// ### hdl/ftc_fault_check.v
`timescale 1ns/100ps
`include "ftc_consts.vh"

// Combinational fault decisions taken from the configuration bits
module ftc_fault_check (
  input  wire        div_en_i,
  input  wire        div_zero_i,
  input  wire        unalign_en_i,
  input  wire        ls_valid_i,
  input  wire [1:0]  ls_size_i,
  input  wire [1:0]  ls_addr_i,
  input  wire        ls_multi_i,
  input  wire        trig_en_i,
  input  wire        trig_req_i,
  input  wire        trig_priv_i,
  input  wire        thread_en_i,
  input  wire        ret_thread_i,
  input  wire        other_active_i,
  input  wire [8:0]  prio_i,
  input  wire [2:0]  pend_i,
  output wire        div_trap_o,
  output wire        div_zero_q_o,
  output wire        ls_fault_o,
  output wire        trig_grant_o,
  output wire        trig_refuse_o,
  output wire        ret_ok_o,
  output wire        ret_fault_o,
  output reg  [2:0]  win_o
);

  wire misaligned;
  integer k;
  reg [2:0] best;

  assign div_trap_o    = div_zero_i & div_en_i;
  assign div_zero_q_o  = div_zero_i & ~div_en_i;
  assign misaligned    = (ls_multi_i || ls_size_i == 2'd2) ? |ls_addr_i :
                         (ls_size_i == 2'd1) ? ls_addr_i[0] : 1'b0;
  assign ls_fault_o    = ls_valid_i & misaligned &
                         (ls_multi_i | unalign_en_i);
  assign trig_grant_o  = trig_req_i & (trig_priv_i | trig_en_i);
  assign trig_refuse_o = trig_req_i & ~trig_priv_i & ~trig_en_i;
  assign ret_ok_o      = ret_thread_i &
                         (thread_en_i | ~other_active_i);
  assign ret_fault_o   = ret_thread_i & ~thread_en_i & other_active_i;

  // Lowest value wins; ties go to the lower handler index
  always @*
  begin
    win_o = 3'b000;
    best  = 3'd7;
    for (k = 0; k < 3; k = k + 1)
    begin
      if (pend_i[k] && (win_o == 3'b000 || prio_i[k*3 +: 3] < best))
      begin
        win_o = 3'b000;
        win_o[k] = 1'b1;
        best  = prio_i[k*3 +: 3];
      end
    end
  end

endmodule // ftc_fault_check

// ### hdl/ftc_top.v
// Design decision made here: register access over Wishbone.
`timescale 1ns/100ps
`include "ftc_consts.vh"

// Summary of operation
// - With the divide trap bit set a divide by zero raises a trap.
// - With the divide trap bit clear a divide by zero gives quotient zero.
// - With the unaligned trap bit set a misaligned halfword or word faults.
// - Misaligned multiple transfers fault regardless.
// - The trigger access bit decides whether unprivileged trigger use passes.
// - With the thread bit clear a return to thread needs no active exception.
// - With the thread bit set a return to thread is allowed from any level.
// - The handler priority register refuses unprivileged reads and writes.
// - Each priority byte may be written alone through its byte lane.
// - Priorities sit at bits 23:21, 15:13 and 7:5.
// - Each field holds a level from zero to seven used by the fault unit.
// - A lower priority value means a more urgent handler.
// - The control register is privileged only and resets to zero.
module ftc_top (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [31:0] adr_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  input  wire        we_i,
  input  wire [3:0]  sel_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        priv_i,
  output reg         ack_o,
  output reg         err_o,
  input  wire        div_req_i,
  input  wire        div_zero_i,
  input  wire [31:0] div_quot_i,
  output reg         div_done_o,
  output reg  [31:0] div_quot_o,
  output reg         div_trap_o,
  input  wire        ls_valid_i,
  input  wire [1:0]  ls_size_i,
  input  wire [1:0]  ls_addr_i,
  input  wire        ls_multi_i,
  output reg         ls_fault_o,
  input  wire        trig_req_i,
  input  wire        trig_priv_i,
  output reg         trig_grant_o,
  output reg         trig_refuse_o,
  input  wire        ret_thread_i,
  input  wire        other_active_i,
  output reg         ret_ok_o,
  output reg         ret_fault_o,
  input  wire [2:0]  pend_i,
  output reg  [2:0]  win_o,
  output reg  [2:0]  prio_mem_o,
  output reg  [2:0]  prio_bus_o,
  output reg  [2:0]  prio_use_o,
  output reg         div_trap_en_o,
  output reg         unalign_trap_en_o,
  output reg         irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  reg                 zero_divisor_trap_en;
  reg                 unalign_trap_en;
  reg                 unpriv_trigger_access_en;
  reg                 thread_entry_any_level;
  // Reset image of the configuration bits, picked apart per field
  localparam [4:0]    cfg_rst_val = `FTC_RST_CFG;
  reg  [`FTC_EV_W-1:0] stat;
  reg  [`FTC_EV_W-1:0] mask;

  wire [11:0]         ofs;
  wire                req;
  wire                hit_cfg;
  wire                hit_pri;
  wire                hit_stat;
  wire                hit_mask;
  wire                hit_any;
  wire                priv_ok;
  wire                do_wr;
  wire                do_rd;
  wire [31:0]         cfg_word;
  wire [31:0]         pri_word;
  reg  [31:0]         next_dat;
  reg  [`FTC_EV_W-1:0] next_stat;
  wire [`FTC_EV_W-1:0] ev;

  wire                c_div_trap;
  wire                c_div_zero_q;
  wire                c_ls_fault;
  wire                c_trig_grant;
  wire                c_trig_refuse;
  wire                c_ret_ok;
  wire                c_ret_fault;
  wire [2:0]          c_win;
  wire [8:0]          prio_flat;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone decode

  // A request is taken only while no answer stands, so one access
  // gives exactly one ack or err pulse
  assign ofs      = {adr_i[11:2], 2'b00};
  assign req      = cyc_i & stb_i & ~ack_o & ~err_o;
  assign hit_cfg  = (ofs == `FTC_OFS_CFG);
  assign hit_pri  = (ofs == `FTC_OFS_PRI);
  assign hit_stat = (ofs == `FTC_OFS_STAT);
  assign hit_mask = (ofs == `FTC_OFS_MASK);
  assign hit_any  = hit_cfg | hit_pri | hit_stat | hit_mask;
  assign priv_ok  = priv_i | ~hit_any;
  assign do_wr    = req & we_i & priv_ok;
  assign do_rd    = req & ~we_i & priv_ok;

  // Reserved positions are built from zeros
  assign cfg_word = {27'h000_0000,
                     zero_divisor_trap_en,
                     unalign_trap_en,
                     1'b0,
                     unpriv_trigger_access_en,
                     thread_entry_any_level};
  assign pri_word = {8'h00,
                     prio_flat[8:6], 5'h00,
                     prio_flat[5:3], 5'h00,
                     prio_flat[2:0], 5'h00};

  always @*
  begin
    next_dat = 32'h0000_0000;
    if (hit_cfg)
    begin
      next_dat = cfg_word;
    end
    else if (hit_pri)
    begin
      next_dat = pri_word;
    end
    else if (hit_stat)
    begin
      next_dat = {{(32-`FTC_EV_W){1'b0}}, stat};
    end
    else if (hit_mask)
    begin
      next_dat = {{(32-`FTC_EV_W){1'b0}}, mask};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one cycle after the request, err on refused access

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req & priv_ok;
      err_o <= req & ~priv_ok;
      // Zero outside a read answer so stale data never lingers
      if (do_rd)
      begin
        dat_o <= next_dat;
      end
      else
      begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and control register

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      zero_divisor_trap_en     <= cfg_rst_val[`FTC_CFG_ZERO_DIVISOR_TRAP_EN];
      unalign_trap_en          <= cfg_rst_val[`FTC_CFG_UNALIGN];
      unpriv_trigger_access_en <= cfg_rst_val[`FTC_CFG_TRIG];
      thread_entry_any_level   <= cfg_rst_val[`FTC_CFG_THREAD];
    end
    // Lane 0 carries every writable configuration bit
    else if (do_wr && hit_cfg && sel_i[0])
    begin
      zero_divisor_trap_en     <= dat_i[`FTC_CFG_ZERO_DIVISOR_TRAP_EN];
      unalign_trap_en          <= dat_i[`FTC_CFG_UNALIGN];
      unpriv_trigger_access_en <= dat_i[`FTC_CFG_TRIG];
      thread_entry_any_level   <= dat_i[`FTC_CFG_THREAD];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handler priority fields, one per byte lane

  // Each field owns its byte lane; untouched lanes keep their value,
  // so software may update one handler alone
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_pri
      reg [2:0] fld;
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          fld <= `FTC_RST_PRI;
        end
        else if (do_wr && hit_pri && sel_i[g])
        begin
          fld <= dat_i[g*8+5 +: 3];
        end
      end
      assign prio_flat[g*3 +: 3] = fld;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output

  // Bus refusals raise an event too, so a stray user access is seen
  assign ev = {req & ~priv_ok,
               c_ret_fault,
               c_trig_refuse,
               c_ls_fault,
               c_div_trap};

  // A new event in the clearing read still lands
  always @*
  begin
    next_stat = stat;
    if (do_rd && hit_stat)
    begin
      next_stat = {`FTC_EV_W{1'b0}};
    end
    next_stat = next_stat | ev;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat  <= `FTC_RST_STAT;
      mask  <= `FTC_RST_MASK;
      irq_o <= 1'b0;
    end
    else
    begin
      stat <= next_stat;
      // Mask writes take lane 0 only; upper lanes are reserved
      if (do_wr && hit_mask && sel_i[0])
      begin
        mask <= dat_i[`FTC_EV_W-1:0];
      end
      irq_o <= |(next_stat & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault decisions

  // The checker is purely combinational; its answers are registered below
  ftc_fault_check u_check (
    .div_en_i       (zero_divisor_trap_en),
    .div_zero_i     (div_req_i & div_zero_i),
    .unalign_en_i   (unalign_trap_en),
    .ls_valid_i     (ls_valid_i),
    .ls_size_i      (ls_size_i),
    .ls_addr_i      (ls_addr_i),
    .ls_multi_i     (ls_multi_i),
    .trig_en_i      (unpriv_trigger_access_en),
    .trig_req_i     (trig_req_i),
    .trig_priv_i    (trig_priv_i),
    .thread_en_i    (thread_entry_any_level),
    .ret_thread_i   (ret_thread_i),
    .other_active_i (other_active_i),
    .prio_i         (prio_flat),
    .pend_i         (pend_i),
    .div_trap_o     (c_div_trap),
    .div_zero_q_o   (c_div_zero_q),
    .ls_fault_o     (c_ls_fault),
    .trig_grant_o   (c_trig_grant),
    .trig_refuse_o  (c_trig_refuse),
    .ret_ok_o       (c_ret_ok),
    .ret_fault_o    (c_ret_fault),
    .win_o          (c_win)
  );

  // Fault answers trail their inputs by one cycle, and the enable
  // mirrors trail the configuration register by one cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_done_o        <= 1'b0;
      div_quot_o        <= 32'h0000_0000;
      div_trap_o        <= 1'b0;
      ls_fault_o        <= 1'b0;
      trig_grant_o      <= 1'b0;
      trig_refuse_o     <= 1'b0;
      ret_ok_o          <= 1'b0;
      ret_fault_o       <= 1'b0;
      win_o             <= 3'b000;
      prio_mem_o        <= `FTC_RST_PRI;
      prio_bus_o        <= `FTC_RST_PRI;
      prio_use_o        <= `FTC_RST_PRI;
      div_trap_en_o     <= 1'b0;
      unalign_trap_en_o <= 1'b0;
    end
    else
    begin
      div_done_o <= div_req_i & ~c_div_trap;
      if (c_div_zero_q)
      begin
        div_quot_o <= 32'h0000_0000;
      end
      else
      begin
        div_quot_o <= div_quot_i;
      end
      div_trap_o        <= c_div_trap;
      ls_fault_o        <= c_ls_fault;
      trig_grant_o      <= c_trig_grant;
      trig_refuse_o     <= c_trig_refuse;
      ret_ok_o          <= c_ret_ok;
      ret_fault_o       <= c_ret_fault;
      win_o             <= c_win;
      prio_mem_o        <= prio_flat[2:0];
      prio_bus_o        <= prio_flat[5:3];
      prio_use_o        <= prio_flat[8:6];
      div_trap_en_o     <= zero_divisor_trap_en;
      unalign_trap_en_o <= unalign_trap_en;
    end
  end

endmodule // ftc_top

// ### verification/ftc_top_sva.sv
`timescale 1ns/100ps
module ftc_top_sva (
  input wire        clk_i,
  input wire        rst_i,
  input wire [31:0] adr_i,
  input wire        we_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        priv_i,
  input wire        ack_o,
  input wire        err_o,
  input wire        div_req_i,
  input wire        div_zero_i,
  input wire        div_done_o,
  input wire [31:0] div_quot_o,
  input wire        div_trap_o,
  input wire        ls_valid_i,
  input wire [1:0]  ls_size_i,
  input wire [1:0]  ls_addr_i,
  input wire        ls_multi_i,
  input wire        ls_fault_o,
  input wire [2:0]  pend_i,
  input wire [2:0]  win_o,
  input wire [2:0]  prio_mem_o,
  input wire [2:0]  prio_bus_o,
  input wire [2:0]  prio_use_o,
  input wire        div_trap_en_o,
  input wire        unalign_trap_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = cyc_i && stb_i && !ack_o && !err_o;
  ////////////////////////////////////////////////////////////////////////
  div_trap_a: assert property (div_req_i && div_zero_i
    |=> !div_trap_en_o || (div_trap_o && !div_done_o))
    else $error("zero divide not trapped");
  div_zero_a: assert property (div_req_i && div_zero_i
    |=> div_trap_en_o || (div_done_o && !div_trap_o
    && div_quot_o == 32'h0000_0000)) else $error("zero divide result wrong");
  unalign_fault_a: assert property (ls_valid_i && !ls_multi_i
    && ls_addr_i[0] && ls_size_i == 2'h1 |=> ls_fault_o == unalign_trap_en_o)
    else $error("unaligned half fault wrong");
  multi_fault_a: assert property (ls_valid_i && ls_multi_i
    && ls_addr_i != 2'h0 |=> ls_fault_o) else $error("multiple not faulted");
  bus_answer_a: assert property (req |=> ack_o != err_o)
    else $error("bus request not answered");
  priv_refuse_a: assert property (req && !priv_i
    && adr_i[11:2] == 10'h346 |=> err_o && !ack_o)
    else $error("unprivileged access not refused");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  prio_hold_a: assert property (!(req && we_i) ##1 !(req && we_i)
    |=> $stable({prio_use_o, prio_bus_o, prio_mem_o}))
    else $error("priority changed without write");
  win_single_a: assert property (pend_i == 3'h1 |=> win_o == 3'h1)
    else $error("single pending not chosen");
endmodule // ftc_top_sva

bind ftc_top ftc_top_sva i_sva (.clk_i(clk_i), .rst_i(rst_i),
  .adr_i(adr_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .priv_i(priv_i), .ack_o(ack_o), .err_o(err_o), .div_req_i(div_req_i),
  .div_zero_i(div_zero_i), .div_done_o(div_done_o),
  .div_quot_o(div_quot_o), .div_trap_o(div_trap_o),
  .ls_valid_i(ls_valid_i), .ls_size_i(ls_size_i), .ls_addr_i(ls_addr_i),
  .ls_multi_i(ls_multi_i), .ls_fault_o(ls_fault_o), .pend_i(pend_i),
  .win_o(win_o), .prio_mem_o(prio_mem_o), .prio_bus_o(prio_bus_o),
  .prio_use_o(prio_use_o), .div_trap_en_o(div_trap_en_o),
  .unalign_trap_en_o(unalign_trap_en_o));

// ### verification/test_ftc_top.sv
`timescale 1ns/100ps
module test_ftc_top;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [31:0] adr_i = 32'h0000_0000;
  reg  [31:0] dat_i = 32'h0000_0000;
  reg         we_i = 1'b0;
  reg  [3:0]  sel_i = 4'h0;
  reg         cyc_i = 1'b0;
  reg         stb_i = 1'b0;
  reg         priv_i = 1'b0;
  reg  [3:0]  pls = 4'h0;
  reg  [7:0]  qual = 8'h00;
  reg  [2:0]  pend_i = 3'h0;
  reg  [31:0] r;
  integer     n_mismatch = 0;
  integer     n_compared = 0;
  wire [31:0] dat_o, div_quot_o;
  wire [6:0]  fo;
  wire [2:0]  win_o, pm, pb, pu;
  wire        ack_o, err_o, den, uen, irq_o;
  ftc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .priv_i(priv_i), .ack_o(ack_o),
    .err_o(err_o), .div_req_i(pls[0]), .div_zero_i(qual[7]),
    .div_quot_i(32'h1234_5678), .div_done_o(fo[5]),
    .div_quot_o(div_quot_o), .div_trap_o(fo[6]), .ls_valid_i(pls[1]),
    .ls_size_i(qual[5:4]), .ls_addr_i(qual[3:2]), .ls_multi_i(qual[6]),
    .ls_fault_o(fo[4]), .trig_req_i(pls[2]), .trig_priv_i(qual[1]),
    .trig_grant_o(fo[3]), .trig_refuse_o(fo[2]), .ret_thread_i(pls[3]),
    .other_active_i(qual[0]), .ret_ok_o(fo[1]), .ret_fault_o(fo[0]),
    .pend_i(pend_i), .win_o(win_o), .prio_mem_o(pm), .prio_bus_o(pb),
    .prio_use_o(pu), .div_trap_en_o(den), .unalign_trap_en_o(uen),
    .irq_o(irq_o));
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task close_out;
    begin
      if (n_mismatch == 0 && n_compared > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
        $display("MISMATCH %0s exp %h got %h", n, e, g);
        n_mismatch = n_mismatch + 1;
      end
    end
  endtask
  task wb(input [11:0] a, input [31:0] d, input w, input [3:0] s,
          input p, input xe);
    integer k;
    begin
      @(posedge clk_i);
      adr_i <= {20'h0_0000, a};
      dat_i <= d;
      we_i <= w;
      sel_i <= s;
      priv_i <= p;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      k = 0;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 20)
      begin
        k = k + 1;
        @(posedge clk_i);
      end
      r = dat_o;
      chk("bus_err", xe, err_o);
      chk("bus_ack", !xe, ack_o);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      wb(a, 32'h0000_0000, 1'b0, 4'hF, 1'b1, 1'b0);
      chk("rdata", e, r);
    end
  endtask
  task step(input [3:0] p, input [7:0] q, input [6:0] e);
    begin
      @(posedge clk_i);
      pls <= p;
      qual <= q;
      @(posedge clk_i);
      pls <= 4'h0;
      @(negedge clk_i);
      chk("fault_out", e, fo);
    end
  endtask
  task pick(input [2:0] p, input [2:0] e);
    begin
      @(posedge clk_i);
      pend_i <= p;
      @(posedge clk_i);
      pend_i <= 3'h0;
      @(negedge clk_i);
      chk("winner", e, win_o);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      rd(12'hD14, 32'h0000_0000);
      rd(12'hD18, 32'h0000_0000);
      chk("prio_rst", 9'h000, {pu, pb, pm});
    end
  endtask
  task t_cfg;
    begin
      wb(12'hD14, 32'h0000_001F, 1'b1, 4'hF, 1'b1, 1'b0);
      rd(12'hD14, 32'h0000_001B);
      chk("trap_en", 2'h3, {den, uen});
      wb(12'hD14, 32'h0000_0000, 1'b1, 4'hF, 1'b0, 1'b1);
      rd(12'hD14, 32'h0000_001B);
    end
  endtask
  task t_fault;
    begin
      step(4'h1, 8'h80, 7'h40);
      step(4'h2, 8'h14, 7'h10);
      step(4'h4, 8'h00, 7'h08);
      step(4'h8, 8'h01, 7'h02);
      wb(12'hD14, 32'h0000_0000, 1'b1, 4'hF, 1'b1, 1'b0);
      step(4'h1, 8'h80, 7'h20);
      chk("quot_zero", 32'h0000_0000, div_quot_o);
      step(4'h2, 8'h14, 7'h00);
      step(4'h2, 8'h68, 7'h10);
      step(4'h4, 8'h00, 7'h04);
      step(4'h4, 8'h02, 7'h08);
      step(4'h8, 8'h01, 7'h01);
      step(4'h8, 8'h00, 7'h02);
      step(4'h1, 8'h00, 7'h20);
      chk("quot", 32'h1234_5678, div_quot_o);
    end
  endtask
  task t_pri;
    begin
      wb(12'hD18, 32'hFFFF_FFFF, 1'b1, 4'hF, 1'b0, 1'b1);
      wb(12'hD18, 32'h0000_0000, 1'b0, 4'hF, 1'b0, 1'b1);
      rd(12'hD18, 32'h0000_0000);
      wb(12'hD18, 32'hFFFF_FF00, 1'b1, 4'h2, 1'b1, 1'b0);
      rd(12'hD18, 32'h0000_E000);
      wb(12'hD18, 32'h0040_0060, 1'b1, 4'h5, 1'b1, 1'b0);
      rd(12'hD18, 32'h0040_E060);
      chk("prio", 9'h0BB, {pu, pb, pm});
      pick(3'h7, 3'h4);
      pick(3'h3, 3'h1);
      rd(12'hD40, 32'h0000_0000);
    end
  endtask
  task t_irq;
    begin
      step(4'h4, 8'h00, 7'h04);
      @(negedge clk_i);
      chk("irq_mask", 1'b0, irq_o);
      wb(12'hD30, 32'h0000_0000, 1'b0, 4'hF, 1'b1, 1'b0);
      wb(12'hD34, 32'h0000_0004, 1'b1, 4'h1, 1'b1, 1'b0);
      step(4'h4, 8'h00, 7'h04);
      @(negedge clk_i);
      chk("irq_set", 1'b1, irq_o);
      rd(12'hD30, 32'h0000_0004);
      repeat (2) @(negedge clk_i);
      chk("irq_clr", 1'b0, irq_o);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_cfg;
    t_fault;
    t_pri;
    t_irq;
    close_out;
  end
  initial
  begin
    #40000;
    n_mismatch = n_mismatch + 1;
    close_out;
  end
endmodule // test_ftc_top
